// File: lif_pkg.sv
package lif_pkg;

    // Register indices; byte address is four times the index.
    localparam logic [7:0] LIF_IDX_PEND_TIMERS = 8'h12;
    localparam logic [7:0] LIF_IDX_PEND_ALARMS = 8'h13;
    localparam logic [7:0] LIF_IDX_PEND_IND    = 8'h14;
    localparam logic [7:0] LIF_IDX_MASK_TIMERS = 8'h15;
    localparam logic [7:0] LIF_IDX_MASK_ALARMS = 8'h16;
    localparam logic [7:0] LIF_IDX_MASK_IND    = 8'h17;
    localparam int         LIF_ADDR_LSB        = 2;
    localparam int         LIF_NREG            = 3;

    // Implemented bits of each pending register.
    localparam logic [7:0] LIF_PEND_MASK_TIMERS = 8'h3f;
    localparam logic [7:0] LIF_PEND_MASK_ALARMS = 8'hff;
    localparam logic [7:0] LIF_PEND_MASK_IND    = 8'h02;
    // Enable bits that gate a source; other stored bits do nothing.
    localparam logic [7:0] LIF_EN_MASK_TIMERS   = 8'h3f;
    localparam logic [7:0] LIF_EN_MASK_ALARMS   = 8'hff;
    localparam logic [7:0] LIF_EN_MASK_IND      = 8'h02;
    // Bits of each enable register that software can store.
    localparam logic [7:0] LIF_EN_STORE_TIMERS  = 8'hff;
    localparam logic [7:0] LIF_EN_STORE_ALARMS  = 8'hff;
    localparam logic [7:0] LIF_EN_STORE_IND     = 8'h03;

    localparam logic [7:0] LIF_RST_PEND = 8'h00;
    localparam logic [7:0] LIF_RST_EN   = 8'h00;

    localparam logic [1:0] LIF_HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] LIF_HTRANS_SEQ    = 2'h3;

    // Source inputs, one per pending bit: event pulses, and the loop closure level.
    typedef struct packed {
        logic [5:0] timers;  // Ring inactive/active, tone2 and tone1.
        logic [5:0] alarms;  // Power alarms 6 down to 1.
        logic       loop_close_level;
        logic       ring_trip;
        logic       indirect_done;
    } lif_events_t;

    // Latched AHB address phase.
    typedef struct packed {
        logic       valid;
        logic       write;
        logic [7:0] index;
    } lif_aphase_t;

endpackage

// File: lif_sync2.sv
`timescale 1ns/1ps
module lif_sync2
    import lif_pkg::*;
(
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic din,
    output logic      dout
);
    logic meta_reg;
    logic sync_reg;

    // Two-flop synchroniser; the first stage feeds only the second.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
        end else begin
            meta_reg <= din;
            sync_reg <= meta_reg;
        end
    end

    assign dout = sync_reg;
endmodule

// File: lif_flag_reg.sv
`timescale 1ns/1ps
module lif_flag_reg
    import lif_pkg::*;
(
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic [7:0] set_bits,
    input  wire logic [7:0] clr_bits,
    input  wire logic [7:0] impl_mask,
    output logic [7:0]      flags
);
    logic [7:0] flags_reg;
    logic [7:0] flags_next;

    // Set wins over a same-cycle write-one clear; zeros leave bits alone.
    always_comb begin
        flags_next = ((flags_reg & ~clr_bits) | set_bits)
                     & impl_mask;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flags_reg <= LIF_RST_PEND;
        end else begin
            flags_reg <= flags_next;
        end
    end

    assign flags = flags_reg;
endmodule

// File: lif_irq_top.sv
// Our own choice: the AHB-Lite slave port.
`timescale 1ns/1ps
module lif_irq_top
    import lif_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic [5:0]  timer_events,
    input  wire logic [5:0]  alarm_events,
    input  wire logic        loop_close_level,
    input  wire logic        ring_trip_event,
    input  wire logic        indirect_done_event,
    output logic             irq
);
    lif_events_t  ev;
    lif_aphase_t  aph_reg;
    lif_aphase_t  aph_next;
    logic [7:0]   en_reg  [LIF_NREG];
    logic [7:0]   en_next [LIF_NREG];
    logic [7:0]   pend    [LIF_NREG];
    logic [7:0]   set_v   [LIF_NREG];
    logic [7:0]   clr_v   [LIF_NREG];
    logic [7:0]   impl_v  [LIF_NREG];
    logic [7:0]   gate_v  [LIF_NREG];
    logic [7:0]   store_v [LIF_NREG];
    logic [31:0]  rdata_reg;
    logic [31:0]  rdata_next;
    logic         loop_prev_reg;
    logic         loop_sync;
    logic         loop_edge;
    logic         irq_reg;
    logic         irq_next;
    logic         wr_hit;
    int           wr_slot;

    // Map a register index to its pending slot (0..2) or enable slot (3..5).
    function automatic int slot_of(input logic [7:0] idx);
        case (idx)
            LIF_IDX_PEND_TIMERS: slot_of = 0;
            LIF_IDX_PEND_ALARMS: slot_of = 1;
            LIF_IDX_PEND_IND:    slot_of = 2;
            LIF_IDX_MASK_TIMERS: slot_of = 3;
            LIF_IDX_MASK_ALARMS: slot_of = 4;
            LIF_IDX_MASK_IND:    slot_of = 5;
            default:             slot_of = -1;
        endcase
    endfunction

    // Only the loop level comes from another clock domain; sync it.
    lif_sync2 u_loop_sync (
        .hclk    (hclk),
        .hresetn (hresetn),
        .din     (loop_close_level),
        .dout    (loop_sync)
    );

    always_comb begin
        ev.timers           = timer_events;
        ev.alarms           = alarm_events;
        ev.loop_close_level = loop_sync;
        ev.ring_trip        = ring_trip_event;
        ev.indirect_done    = indirect_done_event;
    end

    // Loop closure change detector on the synchronised level.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            loop_prev_reg <= 1'b0;
        end else begin
            loop_prev_reg <= ev.loop_close_level;
        end
    end
    assign loop_edge = ev.loop_close_level ^ loop_prev_reg;

    // Source bits placed at their documented pending positions.
    always_comb begin
        set_v[0]  = {2'h0, ev.timers};
        set_v[1]  = {ev.alarms, loop_edge, ev.ring_trip};
        set_v[2]  = {6'h00, ev.indirect_done, 1'b0};
        impl_v[0] = LIF_PEND_MASK_TIMERS;
        impl_v[1] = LIF_PEND_MASK_ALARMS;
        impl_v[2] = LIF_PEND_MASK_IND;
        gate_v[0] = LIF_EN_MASK_TIMERS;
        gate_v[1] = LIF_EN_MASK_ALARMS;
        gate_v[2] = LIF_EN_MASK_IND;
        store_v[0] = LIF_EN_STORE_TIMERS;
        store_v[1] = LIF_EN_STORE_ALARMS;
        store_v[2] = LIF_EN_STORE_IND;
    end

    // Address phase capture; zero wait states, always OKAY.
    always_comb begin
        aph_next = aph_reg;
        if (hready) begin
            aph_next.valid = hsel & (htrans == LIF_HTRANS_NONSEQ ||
                                     htrans == LIF_HTRANS_SEQ);
            aph_next.write = hwrite;
            aph_next.index = haddr[LIF_ADDR_LSB +: 8];
        end
    end

    always_comb begin
        wr_slot = slot_of(aph_reg.index);
        wr_hit  = aph_reg.valid & aph_reg.write;
    end

    // Write-one-clear for pending regs, plain store for enable regs.
    generate
        for (genvar g = 0; g < LIF_NREG; g++) begin : g_regs
            always_comb begin
                clr_v[g] = (wr_hit && wr_slot == g) ? hwdata[7:0]
                                                    : 8'h00;
                en_next[g] = en_reg[g];
                if (wr_hit && wr_slot == g + LIF_NREG) begin
                    en_next[g] = hwdata[7:0] & store_v[g];
                end
            end

            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    en_reg[g] <= LIF_RST_EN;
                end else begin
                    en_reg[g] <= en_next[g];
                end
            end

            lif_flag_reg u_flags (
                .hclk      (hclk),
                .hresetn   (hresetn),
                .set_bits  (set_v[g]),
                .clr_bits  (clr_v[g]),
                .impl_mask (impl_v[g]),
                .flags     (pend[g])
            );
        end
    endgenerate

    // Read data registered at the address phase, zero-filled above 8 bits.
    always_comb begin
        int rs;
        rs = slot_of(haddr[LIF_ADDR_LSB +: 8]);
        rdata_next = 32'h0000_0000;
        if (hready && hsel && !hwrite) begin
            for (int k = 0; k < LIF_NREG; k++) begin
                if (rs == k) begin
                    rdata_next = {24'h000000, pend[k]};
                end
                if (rs == k + LIF_NREG) begin
                    rdata_next = {24'h000000, en_reg[k]};
                end
            end
        end
    end

    // Interrupt level from any enabled pending flag.
    always_comb begin
        irq_next = 1'b0;
        for (int k = 0; k < LIF_NREG; k++) begin
            irq_next = irq_next | |(pend[k] & en_reg[k] & gate_v[k]);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            aph_reg   <= '0;
            rdata_reg <= 32'h0000_0000;
            irq_reg   <= 1'b0;
        end else begin
            aph_reg   <= aph_next;
            rdata_reg <= rdata_next;
            irq_reg   <= irq_next;
        end
    end

    assign hrdata    = rdata_reg;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign irq       = irq_reg;

    // Steps from a loop level change to its pending flag.
    sequence s_loop_change;
        $changed(loop_close_level);
    endsequence

    sequence s_loop_flagged;
        ##3 pend[1][1];
    endsequence

    // Steps from an enabled ring trip to the interrupt.
    sequence s_trip_armed;
        ring_trip_event ##1 en_reg[1][0];
    endsequence

    sequence s_irq_follows;
        ##1 irq;
    endsequence

    // A timer event must read back as pending next cycle.
    a_timer_set_pend: assert property (
        @(posedge hclk) disable iff (!hresetn)
        |timer_events |-> ##1
            (pend[0][5:0] & $past(timer_events)) == $past(timer_events))
        else $error("timer event not latched");

    // Each power alarm lands two bits above its event bit.
    a_alarm_set_pend: assert property (
        @(posedge hclk) disable iff (!hresetn)
        |alarm_events |-> ##1
            (pend[1][7:2] & $past(alarm_events)) == $past(alarm_events))
        else $error("power alarm not at its bit");

    // A detected loop change is flagged next cycle.
    a_loop_edge_pend: assert property (
        @(posedge hclk) disable iff (!hresetn)
        loop_edge |=> pend[1][1])
        else $error("loop change not flagged");

    // A change at the pin is flagged once it has crossed the synchroniser.
    a_loop_pin_pend: assert property (
        @(posedge hclk) disable iff (!hresetn)
        s_loop_change |-> s_loop_flagged)
        else $error("loop pin change not flagged");

    // A ring trip is flagged at bit 0 next cycle.
    a_ring_trip_pend: assert property (
        @(posedge hclk) disable iff (!hresetn)
        ring_trip_event |=> pend[1][0])
        else $error("ring trip not flagged");

    // Indirect completion sets bit 1 only.
    a_ind_done_pend: assert property (
        @(posedge hclk) disable iff (!hresetn)
        indirect_done_event |=> pend[2][1] && !pend[2][0])
        else $error("indirect done misplaced");

    // Writing one clears a flag when no event sets it again.
    a_w1c_clear: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (wr_hit && wr_slot == 0 && hwdata[0] && !timer_events[0])
            |=> !pend[0][0])
        else $error("write one did not clear");

    // Writing zero leaves every alarm flag as it was.
    a_zero_keeps: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (wr_hit && wr_slot == 1 && hwdata[7:0] == 8'h00)
            |=> pend[1] == ($past(pend[1])
                | $past({alarm_events, loop_edge, ring_trip_event})))
        else $error("zero write changed a flag");

    // A ring trip in the same cycle as its clear survives.
    a_set_beats_clr: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (wr_hit && wr_slot == 1 && hwdata[0] && ring_trip_event)
            |=> pend[1][0])
        else $error("event lost to clear");

    // The interrupt follows the enabled pending flags by one cycle.
    a_irq_level: assert property (
        @(posedge hclk) disable iff (!hresetn)
        ##1 irq == $past(|(pend[0] & en_reg[0] & LIF_EN_MASK_TIMERS)
            | |(pend[1] & en_reg[1]) | (pend[2][1] & en_reg[2][1])))
        else $error("irq level wrong");

    // An enabled ring trip raises the interrupt two cycles on.
    a_irq_from_trip: assert property (
        @(posedge hclk) disable iff (!hresetn)
        s_trip_armed |-> s_irq_follows)
        else $error("enabled ring trip gave no irq");

    // Storage bits never raise the interrupt.
    a_spare_no_irq: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (pend[0] == 8'h00 && pend[1] == 8'h00 && !en_reg[2][1])
            |=> !irq)
        else $error("storage bits raised irq");

    // Timer enable stores the whole written byte.
    a_en_store: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (wr_hit && wr_slot == 3) |=> en_reg[0] == $past(hwdata[7:0]))
        else $error("enable write lost");

    // Alarm enable stores the whole written byte.
    a_en2_store: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (wr_hit && wr_slot == 4) |=> en_reg[1] == $past(hwdata[7:0]))
        else $error("alarm enable write lost");

    // Indirect enable keeps only its gate and storage bits.
    a_en3_store: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (wr_hit && wr_slot == 5)
            |=> en_reg[2] == ($past(hwdata[7:0]) & LIF_EN_STORE_IND))
        else $error("indirect enable write wrong");
endmodule

// File: lif_host_model.sv
`timescale 1ns/1ps
// Host on the register bus: single word transfers, one at a time.
module lif_host_model
    import lif_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    output logic             hsel,
    output logic [31:0]      haddr,
    output logic [1:0]       htrans,
    output logic             hwrite,
    output logic [2:0]       hsize,
    output logic [31:0]      hwdata
);
    // The bus starts idle with no transfer requested.
    initial begin
        hsel   = 1'b0;
        haddr  = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize  = 3'h2;
        hwdata = 32'h0;
    end

    // Address phase is held until accepted, then data until accepted.
    task automatic xfer(input logic wr, input logic [7:0] idx,
                        input logic [31:0] wd, output logic [31:0] rd);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= {22'h0, idx, 2'b00};
        htrans <= LIF_HTRANS_NONSEQ;
        hwrite <= wr;
        hsize  <= 3'h2;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
        hsel   <= 1'b0;
        hwdata <= ~wd;  // Stale data is not left looking valid.
    endtask
endmodule

// File: tb_line_interface_interrupt_flags.sv
`timescale 1ns/1ps
`define LIF_CHK(what, exp, got) \
    begin \
        total_checks++; \
        if ((got) !== (exp)) begin \
            fail_count++; \
            $display("[FAIL] %s expected %h seen %h", what, exp, got); \
        end \
    end

module tb_line_interface_interrupt_flags
    import lif_pkg::*;
;
    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        irq;
    lif_events_t ev;
    int          fail_count;
    int          total_checks;
    logic [31:0] rd_val;

    // Free running clock of 5 ns.
    initial hclk = 1'b0;
    always #2.5 hclk = ~hclk;

    lif_host_model u_host (.hclk(hclk), .hready(hreadyout),
        .hrdata(hrdata), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

    lif_irq_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp),
        .timer_events(ev.timers), .alarm_events(ev.alarms),
        .loop_close_level(ev.loop_close_level),
        .ring_trip_event(ev.ring_trip),
        .indirect_done_event(ev.indirect_done), .irq(irq));

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        u_host.xfer(1'b1, idx, {24'h0, d}, rd_val);
    endtask

    task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
        u_host.xfer(1'b0, idx, 32'h0, rd_val);
        `LIF_CHK($sformatf("register %h", idx), exp, rd_val)
        `LIF_CHK("response", 1'b0, hresp)
        `LIF_CHK("ready", 1'b1, hreadyout)
    endtask

    task automatic irq_chk(input logic exp);
        `LIF_CHK("irq", exp, irq)
    endtask

    // One-cycle source pulse; returns once the interrupt has settled.
    task automatic pulse(input logic [5:0] t, input logic [5:0] a,
                         input logic rt, input logic ind);
        @(posedge hclk);
        ev.timers        <= t;
        ev.alarms        <= a;
        ev.ring_trip     <= rt;
        ev.indirect_done <= ind;
        @(posedge hclk);
        ev.timers        <= 6'h0;
        ev.alarms        <= 6'h0;
        ev.ring_trip     <= 1'b0;
        ev.indirect_done <= 1'b0;
        @(posedge hclk);
        #1;
    endtask

    // Fire one source with its enable set, then clear its flag.
    task automatic one_src(input logic [5:0] t, input logic [5:0] a,
                           input logic rt, input logic ind,
                           input logic [7:0] idx, input logic [7:0] bits);
        pulse(t, a, rt, ind);
        irq_chk(1'b1);
        rd_chk(idx, {24'h0, bits});
        wr(idx, 8'h00);
        rd_chk(idx, {24'h0, bits});
        wr(idx, bits);
        rd_chk(idx, 32'h0);
        irq_chk(1'b0);
    endtask

    // Watchdog cuts a hung run short.
    initial begin
        repeat (20000) @(posedge hclk);
        fail_count++;
        report_and_stop();
    end

    // Main sequence of register and event scenarios.
    initial begin
        hresetn      = 1'b0;
        ev           = '0;
        fail_count   = 0;
        total_checks = 0;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        for (int i = 0; i < 6; i++)
            rd_chk(LIF_IDX_PEND_TIMERS + 8'(i), 32'h0);
        irq_chk(1'b0);
        rd_chk(8'h11, 32'h0);
        wr(8'h18, 8'hff);
        rd_chk(8'h18, 32'h0);
        wr(LIF_IDX_MASK_TIMERS, 8'hff);
        rd_chk(LIF_IDX_MASK_TIMERS, 32'hff);
        wr(LIF_IDX_MASK_ALARMS, 8'hff);
        rd_chk(LIF_IDX_MASK_ALARMS, 32'hff);
        wr(LIF_IDX_MASK_IND, 8'hff);
        rd_chk(LIF_IDX_MASK_IND, 32'h03);
        irq_chk(1'b0);
        for (int i = 0; i < 6; i++)
            one_src(6'h1 << i, 6'h0, 1'b0, 1'b0, LIF_IDX_PEND_TIMERS,
                    8'h1 << i);
        for (int i = 0; i < 6; i++)
            one_src(6'h0, 6'h1 << i, 1'b0, 1'b0, LIF_IDX_PEND_ALARMS,
                    8'h4 << i);
        one_src(6'h0, 6'h0, 1'b1, 1'b0, LIF_IDX_PEND_ALARMS, 8'h01);
        one_src(6'h0, 6'h0, 1'b0, 1'b1, LIF_IDX_PEND_IND, 8'h02);
        // Loop closure flags on both directions of the detector.
        for (int k = 0; k < 2; k++) begin
            @(posedge hclk);
            ev.loop_close_level <= ~ev.loop_close_level;
            repeat (6) @(posedge hclk);
            rd_chk(LIF_IDX_PEND_ALARMS, 32'h02);
            irq_chk(1'b1);
            wr(LIF_IDX_PEND_ALARMS, 8'h02);
            rd_chk(LIF_IDX_PEND_ALARMS, 32'h0);
        end
        // A masked source stays pending but raises nothing.
        wr(LIF_IDX_MASK_ALARMS, 8'hfe);
        pulse(6'h0, 6'h0, 1'b1, 1'b0);
        irq_chk(1'b0);
        wr(LIF_IDX_MASK_ALARMS, 8'hff);
        repeat (2) @(posedge hclk);
        #1;
        irq_chk(1'b1);
        // Event in the same cycle as the clear keeps the flag set.
        fork
            wr(LIF_IDX_PEND_ALARMS, 8'h01);
            begin
                repeat (2) @(posedge hclk);
                ev.ring_trip <= 1'b1;
                @(posedge hclk);
                ev.ring_trip <= 1'b0;
            end
        join
        rd_chk(LIF_IDX_PEND_ALARMS, 32'h01);
        wr(LIF_IDX_PEND_ALARMS, 8'h01);
        // Storage bit of the indirect enable gates nothing.
        wr(LIF_IDX_MASK_IND, 8'h01);
        pulse(6'h0, 6'h0, 1'b0, 1'b1);
        irq_chk(1'b0);
        rd_chk(LIF_IDX_PEND_IND, 32'h02);
        report_and_stop();
    end
endmodule
